// ===== rtl/dsp_pkg.sv
// Constants and shared types of the display serial host port.
// Assumes a single 100 MHz system clock and no register bus.
package dsp_pkg;
	localparam int unsigned CLK_MHZ = 100;
	localparam int unsigned BYTE_BITS = 8;
	localparam int unsigned UNIT_BITS_3W = 9;
	localparam int unsigned CNT_W = 4;
	localparam logic [CNT_W-1:0] CNT_ZERO = 4'h0;
	localparam logic [CNT_W-1:0] CNT_ONE = 4'h1;
	localparam logic [CNT_W-1:0] CNT_LAST_4W = 4'h7;
	localparam logic [CNT_W-1:0] CNT_LAST_3W = 4'h8;
	localparam logic [CNT_W-1:0] CNT_LAST_TX = 4'h7;
	localparam int unsigned PIX_W = 200;
	localparam int unsigned PIX_H = 200;
	localparam int unsigned ROW_BYTES = PIX_W / BYTE_BITS;
	localparam int unsigned FB_BYTES = ROW_BYTES * PIX_H;
	localparam int unsigned FB_AW = 13;
	localparam int unsigned XY_W = 8;
	localparam logic [FB_AW-1:0] FB_LAST = 13'h1387;
	localparam logic [FB_AW-1:0] FB_ZERO = 13'h0000;
	localparam logic [FB_AW-1:0] FB_ONE = 13'h0001;
	localparam logic [7:0] BYTE_ZERO = 8'h00;
	// Pin vector layout through the input synchroniser.
	localparam int unsigned PIN_N = 6;
	localparam int unsigned PIN_CS_N = 0;
	localparam int unsigned PIN_SCL = 1;
	localparam int unsigned PIN_SDA = 2;
	localparam int unsigned PIN_DC = 3;
	localparam int unsigned PIN_RST_N = 4;
	localparam int unsigned PIN_STRAP = 5;
	localparam logic [PIN_N-1:0] PIN_RST_VAL = 6'h11;
	typedef enum logic [1:0] {
		DSP_IDLE = 2'b00,
		DSP_RX = 2'b01,
		DSP_RD_WAIT = 2'b11,
		DSP_RD = 2'b10
	} dsp_state_e;
endpackage

// ===== rtl/dsp_if.sv
// Carrier between the pin synchroniser and the serial port core.
// Assumes both ends run on the same system clock.
`timescale 1ns/10ps
interface dsp_if;
	import dsp_pkg::*;
	logic [PIN_N-1:0] raw;
	logic [PIN_N-1:0] clean;
	modport sync_end (input raw, output clean);
	modport core_end (output raw, input clean);
endinterface

// ===== rtl/dsp_sync.sv
// Three-stage synchroniser with agreement filter for the host pins.
// Assumes the pins are asynchronous to clk.
`timescale 1ns/10ps
module dsp_sync
	import dsp_pkg::*;
(
	// Clock and reset.
	input wire logic clk,
	input wire logic nrst,
	// Pins.
	dsp_if.sync_end pins
);
	typedef struct packed {
		logic [PIN_N-1:0] s1;
		logic [PIN_N-1:0] s2;
		logic [PIN_N-1:0] s3;
		logic [PIN_N-1:0] clean;
	} dsp_sync_s;

	dsp_sync_s q, d;

	// A change is accepted only once stages two and three agree.
	always_comb begin
		d = q;
		d.s1 = pins.raw;
		d.s2 = q.s1;
		d.s3 = q.s2;
		for (int i = 0; i < PIN_N; i++) begin
			if (q.s2[i] == q.s3[i]) begin
				d.clean[i] = q.s3[i];
			end
		end
	end

	always_ff @(posedge clk) begin
		if (!nrst) begin
			q <= '{PIN_RST_VAL, PIN_RST_VAL, PIN_RST_VAL, PIN_RST_VAL};
		end else begin
			q <= d;
		end
	end

	assign pins.clean = q.clean;
endmodule

// ===== rtl/dsp_port.sv
// Serial host port of a 200 by 200 bistable display controller with frame store.
// Assumes host pins are asynchronous and the serial clock is well below clk/8.
// Notes on behaviour
// RL1: Serial traffic counts only while select low.
// RL2: Command/data pin high marks a data byte.
// RL3: Command/data pin low marks a command byte.
// RL4: Active-low reset input holds logic in reset.
// RL5: Busy high during waveform or sensor exchange.
// RL6: Host waits for busy low before commands.
// RL7: Strap low selects 4-line mode.
// RL8: Strap high selects 3-line 9-bit mode.
// RL9: Frame store holds 200x200 one-bit pixels.
// RL10: 4-line: 8 bits, rising edge, MSB first.
// RL11: 3-line: flag bit then byte MSB first.
// RL12: Read: bytes out on falling edges, MSB first.
// RL13: 3-line mode ignores the command/data pin.
// RL14: Select high clears the bit counter.
`timescale 1ns/10ps
module dsp_port
	import dsp_pkg::*;
(
	// Clock and reset.
	input wire logic clk,
	input wire logic nrst,
	// Host pins.
	input wire logic cs_n_pin,
	input wire logic scl_pin,
	input wire logic sda_in,
	output logic sda_out,
	output logic sda_oe,
	input wire logic dc_pin,
	input wire logic reset_in_n,
	input wire logic bus_mode_strap,
	output logic busy,
	// Controller side.
	input wire logic wave_active,
	input wire logic tsense_active,
	input wire logic [7:0] read_cmd_code,
	input wire logic [7:0] rd_byte,
	output logic rd_next,
	output logic rx_valid,
	output logic [7:0] rx_byte,
	output logic rx_is_data,
	output logic three_wire,
	// Frame store read port.
	input wire logic [XY_W-1:0] pix_x,
	input wire logic [XY_W-1:0] pix_y,
	output logic pix_bit
);
	typedef struct packed {
		dsp_state_e state;
		logic scl_prev;
		logic [CNT_W-1:0] cnt;
		logic [7:0] sh;
		logic flag;
		logic [7:0] tx;
		logic three;
		logic sda_out;
		logic sda_oe;
		logic busy;
		logic rd_next;
		logic rx_valid;
		logic [7:0] rx_byte;
		logic rx_is_data;
		logic pix_bit;
		logic [FB_AW-1:0] wr_ptr;
		logic [FB_BYTES-1:0][7:0] fb;
	} dsp_port_s;

	dsp_port_s q, d;
	dsp_if pins_if();

	// All host pins cross on one synchroniser so their relative timing is kept.
	assign pins_if.raw = {bus_mode_strap, reset_in_n, dc_pin, sda_in, scl_pin, cs_n_pin};

	dsp_sync u_sync (
		.clk(clk),
		.nrst(nrst),
		.pins(pins_if.sync_end)
	);

	// Byte index of a pixel; rows are packed left to right, MSB first.
	function automatic logic [FB_AW-1:0] fb_index(input logic [XY_W-1:0] x, input logic [XY_W-1:0] y);
		logic [31:0] idx;
		idx = 32'(y) * ROW_BYTES + 32'(x / BYTE_BITS);
		return idx[FB_AW-1:0];
	endfunction

	// Wrap-around step of the frame store write pointer.
	function automatic logic [FB_AW-1:0] ptr_next(input logic [FB_AW-1:0] p);
		return (p == FB_LAST) ? FB_ZERO : p + FB_ONE;
	endfunction

	// One step of the serial bit counter.
	function automatic logic [CNT_W-1:0] cnt_next(input logic [CNT_W-1:0] c);
		return c + CNT_ONE;
	endfunction

	// Bit position of a pixel inside its byte, leftmost pixel in the MSB.
	function automatic logic [2:0] fb_bit(input logic [XY_W-1:0] x);
		logic [31:0] pos;
		pos = BYTE_BITS - 1 - (32'(x) % BYTE_BITS);
		return pos[2:0];
	endfunction

	// Counter value of the last bit of a unit in the given mode.
	function automatic logic [CNT_W-1:0] last_cnt(input logic three);
		return three ? CNT_LAST_3W : CNT_LAST_4W;
	endfunction

	logic cs_n_s, scl_s, sda_s;
	logic dc_s, rst_n_s;
	logic strap_s;
	logic scl_rise, scl_fall, unit_done;
	logic [7:0] got_byte;
	logic got_data;

	always_comb begin
		cs_n_s = pins_if.clean[PIN_CS_N];
		scl_s = pins_if.clean[PIN_SCL];
		sda_s = pins_if.clean[PIN_SDA];
		dc_s = pins_if.clean[PIN_DC];
		rst_n_s = pins_if.clean[PIN_RST_N];
		strap_s = pins_if.clean[PIN_STRAP];
		scl_rise = scl_s & ~q.scl_prev;
		scl_fall = ~scl_s & q.scl_prev;
		unit_done = scl_rise && (q.cnt == last_cnt(q.three)); // see RL10 see RL11
		got_byte = {q.sh[6:0], sda_s};
		// In 3-line mode the pin is ignored and the leading flag decides.
		got_data = q.three ? q.flag : dc_s; // see RL2 see RL3 see RL13
	end

	always_comb begin
		d = q;
		d.rx_valid = 1'b0;
		d.rd_next = 1'b0;
		d.scl_prev = scl_s;
		d.busy = wave_active | tsense_active; // see RL5
		// The pixel port is registered so the wide store mux stays off the output path.
		d.pix_bit = q.fb[fb_index(pix_x, pix_y)][fb_bit(pix_x)]; // see RL9
		if (cs_n_s) begin
			// Mode is only taken between transfers so a strap glitch cannot split a unit.
			d.three = strap_s; // see RL7 see RL8
			d.state = DSP_IDLE;
			d.cnt = CNT_ZERO; // see RL14
			d.sda_oe = 1'b0; // see RL1
		end else begin
			case (q.state)
				DSP_IDLE, DSP_RX: begin
					d.state = DSP_RX;
					if (scl_rise) begin
						d.cnt = cnt_next(q.cnt);
						if (q.three && q.cnt == CNT_ZERO) begin
							d.flag = sda_s; // see RL11
						end else begin
							d.sh = got_byte; // see RL10
						end
					end
					if (unit_done) begin
						d.cnt = CNT_ZERO;
						d.rx_valid = 1'b1;
						d.rx_byte = got_byte;
						d.rx_is_data = got_data;
						if (got_data) begin
							d.fb[q.wr_ptr] = got_byte; // see RL2
							d.wr_ptr = ptr_next(q.wr_ptr);
						end else begin
							d.wr_ptr = FB_ZERO; // see RL3
							if (got_byte == read_cmd_code) begin
								d.tx = rd_byte;
								d.rd_next = 1'b1;
								d.state = q.three ? DSP_RD_WAIT : DSP_RD; // see RL12
							end
						end
					end
				end
				DSP_RD_WAIT: begin
					// The flag bit clocked in ahead of read data is consumed here.
					if (scl_rise) begin
						d.state = DSP_RD; // see RL11 see RL12
					end
				end
				DSP_RD: begin
					if (scl_fall) begin
						d.sda_oe = 1'b1;
						d.sda_out = q.tx[7]; // see RL12
						d.tx = {q.tx[6:0], 1'b0};
						d.cnt = cnt_next(q.cnt);
						// The next byte is fetched as the last bit leaves, so a long read needs no gap.
						if (q.cnt == CNT_LAST_TX) begin
							d.cnt = CNT_ZERO;
							d.tx = rd_byte;
							d.rd_next = 1'b1;
						end
					end
				end
				default: begin
					d.state = DSP_IDLE;
				end
			endcase
		end
	end

	// The reset pin is filtered like any other pin, so a one-clock glitch cannot clear the store.
	always_ff @(posedge clk) begin
		if (!nrst || !rst_n_s) begin // see RL4
			q <= '0;
		end else begin
			q <= d;
		end
	end

	// Every output is a plain register copy.
	assign sda_out = q.sda_out;
	assign sda_oe = q.sda_oe;
	assign busy = q.busy;
	assign rd_next = q.rd_next;
	assign rx_valid = q.rx_valid;
	assign rx_byte = q.rx_byte;
	assign rx_is_data = q.rx_is_data;
	assign three_wire = q.three;
	assign pix_bit = q.pix_bit;
endmodule

// ===== tb/dsp_port_asserts.sv
// Checker of the serial port outputs.
// Assumes a bind onto dsp_port.
`timescale 1ns/10ps
module dsp_chk(
	input logic clk, nrst, reset_in_n, cs_n_pin, bus_mode_strap, wave_active, tsense_active,
	input logic sda_oe, busy, rd_next, rx_valid, rx_is_data, three_wire,
	input logic [7:0] rx_byte
);
	default clocking @(posedge clk); endclocking
	default disable iff (!nrst || !reset_in_n);
	property p_rst; disable iff (1'b0) !nrst |=> !(busy | rx_valid | rd_next | sda_oe); endproperty
	a_rst: assert property (p_rst) else $error("not reset");
	property p_busy; nrst |=> busy == $past(wave_active | tsense_active); endproperty
	a_busy: assert property (p_busy) else $error("busy");
	property p_idle; cs_n_pin [*8] |-> !(sda_oe | rx_valid | rd_next); endproperty
	a_idle: assert property (p_idle) else $error("idle");
	property p_rxp; rx_valid |=> !rx_valid; endproperty
	a_rxp: assert property (p_rxp) else $error("unit pulse");
	property p_rdp; rd_next |=> !rd_next; endproperty
	a_rdp: assert property (p_rdp) else $error("load pulse");
	property p_hold; !rx_valid |-> $stable({rx_is_data, rx_byte}); endproperty
	a_hold: assert property (p_hold) else $error("unit hold");
	property p_mode; (cs_n_pin && $stable(bus_mode_strap)) [*8] |-> three_wire == bus_mode_strap; endproperty
	a_mode: assert property (p_mode) else $error("mode");
	property p_oef; $fell(sda_oe) |-> $past(cs_n_pin, 3); endproperty
	a_oef: assert property (p_oef) else $error("drive end");
	c_data: cover property (rx_valid && rx_is_data);
	c_three: cover property (rx_valid && three_wire);
	c_read: cover property (rd_next);
endmodule
bind dsp_port dsp_chk u_chk(.*);

// ===== tb/dsp_host.sv
// Host model that sends units on the serial pins.
// Assumes its tasks are called at falling clock edges.
`timescale 1ns/10ps
module dsp_host(
	input logic clk, sda_out, busy,
	output logic cs_n_pin, scl_pin, sda_h, dc_pin
);
	initial {cs_n_pin, scl_pin, sda_h, dc_pin} = 4'h8;
	// A long low phase lets the falling serial clock cross the synchroniser and the read bit appear before it is sampled.
	task automatic bits(input logic [8:0] u, input int n, output logic [7:0] r);
		for (int i = n - 1; i >= 0; i--) begin
			sda_h = u[i];
			repeat (8) @(negedge clk);
			r = {r[6:0], sda_out};
			scl_pin = 1;
			repeat (5) @(negedge clk);
			scl_pin = 0;
		end
	endtask
	task automatic sel(input logic c, input logic dc);
		cs_n_pin = c;
		dc_pin = dc;
	endtask
	task automatic frame(input logic [8:0] u, input int n);
		logic [7:0] r;
		while (busy) @(negedge clk);
		cs_n_pin = 0;
		bits(u, n, r);
		repeat (6) @(negedge clk);
		cs_n_pin = 1;
		sda_h = ~sda_h;
		repeat (10) @(negedge clk);
	endtask
endmodule

// ===== tb/dsp_port_tb_top.sv
// Self-checking bench of the serial host port.
// Assumes the host model and the bound checker.
`timescale 1ns/10ps
module dsp_port_tb_top;
	logic clk = 0, nrst = 0, bus_mode_strap = 0, wave_active = 0, tsense_active = 0, reset_in_n = 1;
	logic cs_n_pin, scl_pin, sda_h, sda_in, dc_pin, sda_out, sda_oe, busy, rd_next, rx_valid;
	logic rx_is_data, three_wire, pix_bit;
	logic [7:0] read_cmd_code = 8'h2f, rd_byte = 8'h00, pix_x = 8'h00, pix_y = 8'h00, rx_byte, r;
	logic [8:0] u;
	logic [31:0] lf = 32'h0000_ba1d;
	int errors = 0, checked = 0, cyc = 0;
	assign sda_in = sda_oe ? sda_out : sda_h;
	dsp_host u_host(.*);
	dsp_port u_dut(.*);
	initial forever #5 clk = ~clk;
	function automatic logic [31:0] nx(input logic [31:0] v);
		return {v[30:0], v[31] ^ v[21] ^ v[1] ^ v[0]};
	endfunction
	task automatic chk(input string s, input logic [8:0] seen, input logic [8:0] exp);
		checked++;
		if (seen !== exp) begin
			errors++;
			$display("CHECK FAILED %s expected %h seen %h", s, exp, seen);
		end
	endtask
	task automatic close_out;
		$display("checked %0d errors %0d", checked, errors);
		if (errors == 0 && checked > 0) $display("[ PASS ]");
		else $display("[ FAIL ]");
		$finish;
	endtask
	always @(posedge clk) begin
		cyc++;
		if (cyc == 6000) begin
			errors++;
			close_out;
		end
	end
	initial begin
		repeat (12) @(negedge clk);
		nrst = 1;
		for (int m = 0; m < 2; m++) begin
			bus_mode_strap = m[0];
			repeat (10) @(negedge clk);
			for (int i = 0; i < 5; i++) begin
				lf = nx(lf);
				u = {lf[8], lf[7:0] & 8'hdf};
				u_host.sel(1'b1, u[8] & !m[0]);
				u_host.frame(u, 8 + m);
				chk("unit", {rx_is_data, rx_byte}, u);
			end
			$display("mode %0d done", m);
		end
		u_host.frame(9'h1ff, 3);
		u_host.frame(9'h0a5, 9);
		chk("partial", {rx_is_data, rx_byte}, 9'h0a5);
		u_host.frame({1'b1, lf[23:16]}, 9);
		chk("pixel", {8'h00, pix_bit}, {8'h00, lf[23]});
		for (int m = 0; m < 2; m++) begin
			bus_mode_strap = m[0];
			lf = nx(lf);
			rd_byte = lf[31:24];
			repeat (10) @(negedge clk);
			u_host.sel(1'b0, 1'b0);
			u_host.bits(9'h02f, 8 + m, r);
			if (m) u_host.bits(9'h001, 1, r);
			else u_host.sel(1'b0, 1'b1);
			u_host.bits(9'h000, 8, r);
			chk("read", {1'b0, r}, {1'b0, rd_byte});
			u_host.sel(1'b1, 1'b0);
			repeat (10) @(negedge clk);
		end
		$display("read done");
		reset_in_n = 0;
		repeat (8) @(negedge clk);
		chk("reset unit", {rx_is_data, rx_byte}, 9'h000);
		chk("reset pixel", {8'h00, pix_bit}, 9'h000);
		reset_in_n = 1;
		repeat (8) @(negedge clk);
		chk("cleared store", {8'h00, pix_bit}, 9'h000);
		$display("reset done");
		// The host stays quiet while busy may be high.
		repeat (20) begin
			lf = nx(lf);
			{wave_active, tsense_active} = lf[1:0];
			@(negedge clk);
			chk("busy", {8'h00, busy}, {8'h00, |lf[1:0]});
		end
		close_out;
	end
endmodule
